// file: hdl/stc_regs.sv
// Purpose: Register bank that lets firmware drive a storage host core and test generator
// Assumes: Core and test generator share i_clk; only the link-up pin is asynchronous
// Notes: Read data appear in the cycle after the read strobe
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
// Operation
// - Connected status bit 1 rises only when the connection is fully established.
// - Status bit 3 flags any error in connect, disconnect or command.
// - Writing command bit 0 launches: zero writes, one reads.
// - A command goes to the core interface and busy bit 4 rises.
// - Busy clears only when command done or core error, and core and generator idle.
// - Status bit 5 flags verification failure; the command keeps running.
// - Transferred byte count stays readable and live during a command.
// - Clearing enable disconnects; connected drops once sessions are torn down.
// - Error type register exposes individual error cause flags.
// - Status bit 0 shows the Ethernet link is up.
module stc_regs (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [stc_pkg::ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_link_up,
    input wire logic i_core_connected,
    input wire logic i_core_error,
    input wire logic i_core_busy,
    input wire logic i_gen_busy,
    input wire logic i_gen_done,
    input wire logic i_verify_fail,
    input wire logic [31:0] i_error_type,
    input wire logic [47:0] i_capacity,
    input wire logic [56:0] i_byte_count,
    output logic o_conn_en,
    output logic o_cmd_req,
    output logic o_cmd_dir,
    output logic [47:0] o_start_addr,
    output logic [47:0] o_xfer_len,
    output logic [stc_pkg::PATTERN_W-1:0] o_pattern
);
    import stc_pkg::*;

    logic link_up;
    logic conn_en_reg;
    logic [47:0] start_reg;
    logic [47:0] len_reg;
    logic [PATTERN_W-1:0] pattern_reg;
    logic cmd_dir_reg;
    logic cmd_req_reg;
    logic busy_reg;
    logic error_reg;
    logic vfail_reg;
    logic [31:0] rdata_reg;
    stc_cmd_state_e state_reg;
    stc_cmd_state_e state_next;

    stc_sync u_link_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async(i_link_up),
        .o_level(link_up)
    );

    wire hit_conn = i_wr && (i_addr == OFS_CONN_EN);
    wire hit_cmd = i_wr && (i_addr == OFS_USER_CMD);
    // Refused launches leave no trace, so firmware must poll busy afterwards
    wire cmd_accept = hit_cmd && !busy_reg && i_core_connected && conn_en_reg;
    wire hit_start_lo = i_wr && (i_addr == OFS_START_LO);
    wire hit_start_hi = i_wr && (i_addr == OFS_START_HI);
    wire hit_len_lo = i_wr && (i_addr == OFS_LEN_LO);
    wire hit_len_hi = i_wr && (i_addr == OFS_LEN_HI);
    wire hit_pattern = i_wr && (i_addr == OFS_PATTERN);
    // Both core and generator must be idle before busy may fall
    wire all_idle = !i_core_busy && !i_gen_busy;

    wire [31:0] status_word = {26'h0, vfail_reg, busy_reg, error_reg, 1'b0,
                               i_core_connected, link_up};

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CS_IDLE: begin
                if (cmd_accept) begin
                    state_next = CS_ISSUE;
                end
            end
            CS_ISSUE: begin
                state_next = CS_RUN;
            end
            CS_RUN: begin
                if (i_gen_done || i_core_error) begin
                    state_next = CS_DRAIN;
                end
            end
            CS_DRAIN: begin
                if (all_idle) begin
                    state_next = CS_IDLE;
                end
            end
            default: begin
                state_next = CS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= CS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            conn_en_reg <= 1'b0;
            start_reg <= 48'h0;
            len_reg <= 48'h0;
            pattern_reg <= '0;
            cmd_dir_reg <= CMD_WRITE;
        end else begin
            if (hit_conn) begin
                conn_en_reg <= i_wdata[0];
            end
            if (hit_start_lo) begin
                start_reg[31:0] <= i_wdata;
            end
            if (hit_start_hi) begin
                start_reg[47:32] <= i_wdata[15:0];
            end
            if (hit_len_lo) begin
                len_reg[31:0] <= i_wdata;
            end
            if (hit_len_hi) begin
                len_reg[47:32] <= i_wdata[15:0];
            end
            if (hit_pattern) begin
                pattern_reg <= i_wdata[PATTERN_W-1:0];
            end
            if (cmd_accept) begin
                cmd_dir_reg <= i_wdata[CMD_DIR_BIT];
            end
        end
    end

    // Busy rises on launch and holds through drain
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cmd_req_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            cmd_req_reg <= cmd_accept;
            if (cmd_accept) begin
                busy_reg <= 1'b1;
            end else if (state_reg == CS_DRAIN && all_idle) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // Sticky flags; a new launch clears them, but a same-cycle event wins
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            error_reg <= 1'b0;
            vfail_reg <= 1'b0;
        end else begin
            if (i_core_error) begin
                error_reg <= 1'b1;
            end else if (cmd_accept || hit_conn) begin
                error_reg <= 1'b0;
            end
            if (i_verify_fail) begin
                vfail_reg <= 1'b1;
            end else if (cmd_accept) begin
                vfail_reg <= 1'b0;
            end
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        case (i_addr)
            OFS_CONN_EN: rd_mux = {31'h0, conn_en_reg};
            OFS_USER_CMD: rd_mux = {31'h0, cmd_dir_reg};
            OFS_HOST_STATUS: rd_mux = status_word;
            OFS_START_LO: rd_mux = start_reg[31:0];
            OFS_START_HI: rd_mux = {16'h0, start_reg[47:32]};
            OFS_LEN_LO: rd_mux = len_reg[31:0];
            OFS_LEN_HI: rd_mux = {16'h0, len_reg[47:32]};
            OFS_PATTERN: rd_mux = {{(32-PATTERN_W){1'b0}}, pattern_reg};
            OFS_CAP_LO: rd_mux = i_capacity[31:0];
            OFS_CAP_HI: rd_mux = {16'h0, i_capacity[47:32]};
            OFS_ERR_TYPE: rd_mux = i_error_type;
            OFS_BYTES_LO: rd_mux = i_byte_count[31:0];
            OFS_BYTES_HI: rd_mux = {7'h0, i_byte_count[56:32]};
            default: rd_mux = RESET_WORD;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_reg <= RESET_WORD;
        end else if (i_rd) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= RESET_WORD;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_conn_en = conn_en_reg;
    assign o_cmd_req = cmd_req_reg;
    assign o_cmd_dir = cmd_dir_reg;
    assign o_start_addr = start_reg;
    assign o_xfer_len = len_reg;
    assign o_pattern = pattern_reg;

    sequence s_launch;
        cmd_accept ##1 (cmd_req_reg && busy_reg);
    endsequence

    a_launch_busy_rise: assert property (@(posedge i_clk) disable iff (!i_nrst)
        cmd_accept |-> ##1 (o_cmd_req && status_word[STS_BUSY]))
        else $error("busy or request missing after launch");
    a_busy_waits_idle: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $fell(busy_reg) |-> $past(all_idle) && $past(state_reg == CS_DRAIN))
        else $error("busy dropped before idle");
    a_busy_ignores_cmd: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (hit_cmd && busy_reg) |=> !cmd_req_reg && $stable(cmd_dir_reg))
        else $error("command accepted while busy");
    a_noconn_ignores_cmd: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (hit_cmd && !i_core_connected) |=> !cmd_req_reg)
        else $error("command accepted without connection");
    a_error_sticky_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_core_error |=> status_word[STS_ERROR])
        else $error("error flag not set");
    a_vfail_sticky_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_verify_fail |=> status_word[STS_VERIFY_FAIL] &&
            (busy_reg || !$past(busy_reg) || $past(state_reg == CS_DRAIN && all_idle)))
        else $error("verify flag not set");
    a_dir_capture: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_launch |-> o_cmd_dir == $past(i_wdata[CMD_DIR_BIT]))
        else $error("direction not captured");
    a_connected_bit: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_rd && i_addr == OFS_HOST_STATUS) |=>
            o_rdata[STS_CONNECTED] == $past(i_core_connected))
        else $error("connected bit mismatch");
    a_conn_en_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
        hit_conn |=> o_conn_en == $past(i_wdata[0]))
        else $error("enable not written");
    a_byte_count_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_rd && i_addr == OFS_BYTES_LO) |=> o_rdata == $past(i_byte_count[31:0]))
        else $error("byte count not live");
    a_error_type_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_rd && i_addr == OFS_ERR_TYPE) |=> o_rdata == $past(i_error_type))
        else $error("error type not returned");
endmodule

// file: common/stc_pkg.sv
// Purpose: Constants for the storage test control register bank
// Assumes: 32-bit register port, byte addresses, one aligned word per register
// Notes: Offsets without a printed value are local choices
package stc_pkg;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_CONN_EN = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_USER_CMD = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_HOST_STATUS = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_START_LO = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_START_HI = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_LEN_LO = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_LEN_HI = 12'h01C;
    localparam logic [ADDR_W-1:0] OFS_PATTERN = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_CAP_LO = 12'h410;
    localparam logic [ADDR_W-1:0] OFS_CAP_HI = 12'h414;
    localparam logic [ADDR_W-1:0] OFS_ERR_TYPE = 12'h430;
    localparam logic [ADDR_W-1:0] OFS_BYTES_LO = 12'h590;
    localparam logic [ADDR_W-1:0] OFS_BYTES_HI = 12'h594;
    localparam int STS_LINK_UP = 0;
    localparam int STS_CONNECTED = 1;
    localparam int STS_ERROR = 3;
    localparam int STS_BUSY = 4;
    localparam int STS_VERIFY_FAIL = 5;
    localparam int CMD_DIR_BIT = 0;
    localparam logic CMD_WRITE = 1'b0;
    localparam logic CMD_READ = 1'b1;
    localparam int PATTERN_W = 3;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam int SYNC_STAGES = 3;
    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_ISSUE = 2'b01,
        CS_RUN = 2'b10,
        CS_DRAIN = 2'b11
    } stc_cmd_state_e;
endpackage

// file: hdl/stc_sync.sv
// Purpose: Three-stage synchroniser for a level from another domain
// Assumes: Input is a slow level
// Notes: Output changes only once stages two and three agree
`timescale 1ns/10ps
module stc_sync (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_async,
    output logic o_level
);
    logic [2:0] sh_reg;
    logic level_reg;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sh_reg <= 3'h0;
            level_reg <= 1'b0;
        end else begin
            sh_reg <= {sh_reg[1:0], i_async};
            if (sh_reg[1] == sh_reg[2]) begin
                level_reg <= sh_reg[2];
            end
        end
    end
    assign o_level = level_reg;
endmodule

// file: sim/stc_core_model.sv
// Purpose: Behavioural storage core and test generator facing the register bank
// Assumes: A command runs RUN_LEN cycles, one 4 Kbyte unit per cycle
// Notes: Session follows the enable two cycles late so connect is never instant
`timescale 1ns/10ps
module stc_core_model #(
    parameter int RUN_LEN = 8
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_conn_en,
    input wire logic i_cmd_req,
    output logic o_connected,
    output logic o_core_busy,
    output logic o_gen_busy,
    output logic o_done,
    output logic [56:0] o_bytes
);
    logic [1:0] sess_reg;
    logic [7:0] run_reg;
    assign o_connected = sess_reg[1];
    assign o_gen_busy = run_reg != 8'h00;
    assign o_done = run_reg == 8'h01;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sess_reg <= 2'h0;
            run_reg <= 8'h00;
            o_core_busy <= 1'b0;
            o_bytes <= 57'h0;
        end else begin
            sess_reg <= {sess_reg[0], i_conn_en};
            // Core goes idle a cycle after the generator, so drain is exercised
            o_core_busy <= o_gen_busy || i_cmd_req;
            if (i_cmd_req) begin
                run_reg <= 8'(RUN_LEN);
                o_bytes <= 57'h0;
            end else if (o_gen_busy) begin
                run_reg <= run_reg - 8'h01;
                o_bytes <= o_bytes + 57'h1000;
            end
        end
    end
endmodule

// file: sim/tb_stc_regs.sv
// Purpose: Self-checking bench for the storage test control register bank
// Assumes: Core model runs each command for eight 4 Kbyte units
// Notes: Errors and verify failures are pulsed by the bench itself
`timescale 1ns/10ps
module tb_stc_regs;
    import stc_pkg::*;
    logic i_clk, i_nrst, i_wr, i_rd, i_link_up, i_core_error, i_verify_fail;
    logic [ADDR_W-1:0] i_addr;
    logic [31:0] i_wdata, o_rdata, i_error_type, rdat;
    logic cconn, cbusy, gbusy, gdone, o_conn_en, o_cmd_req, o_cmd_dir;
    logic [56:0] bytes;
    logic [47:0] o_start_addr, o_xfer_len;
    logic [PATTERN_W-1:0] o_pattern;
    int err_count = 0;
    int samples_checked = 0;
    int req_count = 0;
    stc_regs i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_link_up(i_link_up),
        .i_core_connected(cconn), .i_core_error(i_core_error), .i_core_busy(cbusy),
        .i_gen_busy(gbusy), .i_gen_done(gdone), .i_verify_fail(i_verify_fail),
        .i_error_type(i_error_type), .i_capacity(48'h00AB_1234_5678), .i_byte_count(bytes),
        .o_conn_en(o_conn_en), .o_cmd_req(o_cmd_req), .o_cmd_dir(o_cmd_dir),
        .o_start_addr(o_start_addr), .o_xfer_len(o_xfer_len), .o_pattern(o_pattern));
    stc_core_model i_core (.i_clk(i_clk), .i_nrst(i_nrst), .i_conn_en(o_conn_en),
        .i_cmd_req(o_cmd_req), .o_connected(cconn), .o_core_busy(cbusy),
        .o_gen_busy(gbusy), .o_done(gdone), .o_bytes(bytes));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // Launch pulses are counted away from the edge that makes them
    always @(negedge i_clk) begin
        if (o_cmd_req === 1'b1) begin
            req_count++;
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        rdat = o_rdata;
    endtask
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        rd(a);
        chk(rdat, e);
    endtask
    // Bounded wait on status bits under a mask
    task automatic poll(input logic [31:0] m, input logic [31:0] e);
        int n;
        n = 0;
        do begin
            rd(OFS_HOST_STATUS);
            n++;
        end while ((rdat & m) !== e && n < 50);
        chk(rdat & m, e);
    endtask
    task automatic pulse_ev(input logic err);
        @(posedge i_clk);
        i_core_error <= err;
        i_verify_fail <= !err;
        @(posedge i_clk);
        i_core_error <= 1'b0;
        i_verify_fail <= 1'b0;
    endtask
    initial begin
        repeat (5000) @(posedge i_clk);
        err_count++;
        end_of_test();
    end
    initial begin
        i_nrst = 1'b0;
        {i_wr, i_rd, i_link_up, i_core_error, i_verify_fail} = 5'h00;
        i_addr = 12'h000;
        i_wdata = 32'h0;
        i_error_type = 32'h0;
        repeat (3) @(posedge i_clk);
        i_nrst <= 1'b1;
        rd_chk(OFS_HOST_STATUS, 32'h0);
        for (int w = 0; w < 4; w++) begin
            wr(12'h100 + 12'(4 * w), (w == 3) ? 32'h0 : 32'h6E61_6D65);
        end
        rd_chk(12'h100, 32'h0);
        rd_chk(OFS_CAP_HI, 32'h0000_00AB);
        i_link_up <= 1'b1;
        repeat (6) @(posedge i_clk);
        rd_chk(OFS_HOST_STATUS, 32'h1);
        wr(OFS_USER_CMD, 32'h1);
        rd_chk(OFS_HOST_STATUS, 32'h1);
        $display("test link and idle done");
        wr(OFS_CONN_EN, 32'h1);
        poll(32'h2, 32'h2);
        chk({31'h0, o_conn_en}, 32'h1);
        wr(OFS_START_LO, 32'h10);
        wr(OFS_START_HI, 32'hCD);
        wr(OFS_LEN_LO, 32'h18);
        wr(OFS_PATTERN, 32'h5);
        rd_chk(OFS_START_HI, 32'hCD);
        chk(o_start_addr[31:0], 32'h10);
        chk(o_xfer_len[31:0], 32'h18);
        chk({29'h0, o_pattern}, 32'h5);
        for (int d = 0; d < 2; d++) begin
            wr(OFS_USER_CMD, 32'(d));
            rd_chk(OFS_HOST_STATUS, 32'h13);
            wr(OFS_USER_CMD, 32'(1 - d));
            poll(32'h10, 32'h0);
            chk({31'h0, o_cmd_dir}, 32'(d));
            rd_chk(OFS_BYTES_LO, 32'h8000);
        end
        $display("test commands done");
        i_error_type <= 32'h4;
        wr(OFS_USER_CMD, 32'h1);
        pulse_ev(1'b0);
        rd_chk(OFS_HOST_STATUS, 32'h33);
        pulse_ev(1'b1);
        rd(OFS_HOST_STATUS);
        chk(rdat & 32'h2B, 32'h2B);
        rd_chk(OFS_ERR_TYPE, 32'h4);
        poll(32'h10, 32'h0);
        $display("test error flags done");
        wr(OFS_CONN_EN, 32'h0);
        poll(32'h2, 32'h0);
        chk(rdat & 32'h8, 32'h0);
        wr(OFS_CONN_EN, 32'h1);
        poll(32'h2, 32'h2);
        chk(32'(req_count), 32'h3);
        $display("test disconnect done");
        end_of_test();
    end
endmodule
